// ==== core/rip_pkg.sv ====
// Shared constants, types and helpers of the integer pipeline
package rip_pkg;
  localparam logic [31:0] RESET_PC    = 32'h0000_0000;
  localparam logic [31:0] TRAP_BASE   = 32'h0000_1000;
  localparam logic [7:0]  TT_IRQ_BASE = 8'h10;
  localparam logic        ET_RESET    = 1'b1;
  localparam logic        S_RESET     = 1'b1;
  localparam logic [2:0]  CWP_RESET   = 3'h0;
  // Instruction field positions
  localparam int OP_LSB    = 30;
  localparam int RD_LSB    = 25;
  localparam int ANNUL_BIT = 29;
  localparam int COND_LSB  = 25;
  localparam int OP2_LSB   = 22;
  localparam int OP3_LSB   = 19;
  localparam int RS1_LSB   = 14;
  localparam int IMM_BIT   = 13;
  localparam int ASI_LSB   = 5;
  localparam int RS2_LSB   = 0;
  // Major opcodes and sub-opcodes
  localparam logic [1:0] OP_FMT2 = 2'h0;
  localparam logic [1:0] OP_CALL = 2'h1;
  localparam logic [1:0] OP_ALU  = 2'h2;
  localparam logic [2:0] OP2_BCC   = 3'h2;
  localparam logic [2:0] OP2_SETHI = 3'h4;
  localparam logic [5:0] OP3_ADDCC = 6'h10;
  localparam logic [5:0] OP3_SUBCC = 6'h14;
  localparam logic [5:0] OP3_FPOP  = 6'h34;
  localparam logic [5:0] OP3_JMPL  = 6'h38;
  localparam logic [5:0] OP3_RETT  = 6'h39;
  localparam logic [5:0] OP3_SAVE  = 6'h3c;
  localparam logic [5:0] OP3_REST  = 6'h3d;
  localparam logic [3:0] COND_ALWAYS = 4'h8;
  localparam logic [4:0] LINK_REG    = 5'h0f;
  // Address space codes
  localparam logic [7:0] ASI_USER_INSN = 8'h08;
  localparam logic [7:0] ASI_SUP_INSN  = 8'h09;
  localparam logic [7:0] ASI_USER_DATA = 8'h0a;
  localparam logic [7:0] ASI_SUP_DATA  = 8'h0b;
  // Register file shape
  localparam int NUM_WIN  = 8;
  localparam int WIN_REGS = 24;
  localparam int NUM_GLOB = 8;
  localparam int NUM_PHYS = 136;

  typedef logic [7:0] rip_preg_t;
  typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} rip_alu_e;
  typedef struct packed {
    logic      valid;
    rip_alu_e  op;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] sd;
    rip_preg_t rd;
    logic      wr;
    logic      load;
    logic      store;
    logic      setcc;
    logic [7:0] asi;
  } rip_ex_s;
  typedef struct packed {
    logic      valid;
    logic      wr;
    logic      load;
    rip_preg_t rd;
    logic [31:0] res;
  } rip_wb_s;

  // Ins of window w alias outs of window w+1; globals sit below the windows
  function automatic rip_preg_t rip_phys(input logic [4:0] r, input logic [2:0] cwp);
    logic [6:0] ofs;
    ofs = 7'({cwp, 4'h0}) + 7'(r - 5'h08);
    return (r < 5'h08) ? rip_preg_t'(r) : rip_preg_t'(ofs) + 8'h08;
  endfunction
endpackage

// ==== core/rip_regfile.sv ====
// Windowed register file: physical entries, two operand reads and a store-data read
`timescale 1ns/10ps
module rip_regfile (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Read ports
  input  wire rip_pkg::rip_preg_t ra1,
  input  wire rip_pkg::rip_preg_t ra2,
  input  wire rip_pkg::rip_preg_t ra3,
  output logic [31:0]            rd1,
  output logic [31:0]            rd2,
  output logic [31:0]            rd3,
  // Write port
  input  wire logic              we,
  input  wire rip_pkg::rip_preg_t wa,
  input  wire logic [31:0]       wd
);
  import rip_pkg::*;
  logic [31:0] mem_reg [NUM_PHYS];

  // Entry zero is never written so it always reads as zero
  genvar i;
  generate
    for (i = 0; i < NUM_PHYS; i++) begin : g_ent
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_reg[i] <= 32'h0;
        end else if (we && wa == rip_preg_t'(i) && i != 0) begin
          mem_reg[i] <= wd;
        end
      end
    end
  endgenerate

  assign rd1 = mem_reg[ra1];
  assign rd2 = mem_reg[ra2];
  assign rd3 = mem_reg[ra3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  write_read_a: assert property (
    we && wa != 8'h00 |=> mem_reg[$past(wa)] == $past(wd))
    else $error("register write not stored");
  zero_reg_a: assert property (
    ra1 == 8'h00 |-> rd1 == 32'h0)
    else $error("register zero not zero");
endmodule

// ==== core/rip_core.sv ====
// Four-stage interlocked integer pipeline with windowed registers
`timescale 1ns/10ps
module rip_core (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Instruction fetch
  output logic             imem_req,
  output logic [31:0]      imem_addr,
  output logic [7:0]       imem_asi,
  input  wire logic [31:0] imem_rdata,
  input  wire logic        imem_ready,
  // Data memory
  output logic             dmem_req,
  output logic             dmem_we,
  output logic [31:0]      dmem_addr,
  output logic [7:0]       dmem_asi,
  output logic [31:0]      dmem_wdata,
  input  wire logic [31:0] dmem_rdata,
  input  wire logic        dmem_ready,
  // Floating-point dispatch
  output logic             fp_valid,
  output logic [31:0]      fp_instr,
  input  wire logic        fp_ready,
  // Interrupts
  input  wire logic [3:0]  irq_level,
  output logic             irq_ack,
  output logic [3:0]       irq_ack_level
);
  import rip_pkg::*;

  logic [3:0]  irq_s1_reg, irq_s2_reg, irq_lvl_reg;
  logic [31:0] pc_reg, d_ir_reg, d_pc_reg, trap_pc_reg, fp_instr_reg;
  logic [31:0] dmem_addr_reg, dmem_wdata_reg;
  logic [7:0]  dmem_asi_reg, imem_asi_reg;
  logic [2:0]  cwp_reg;
  logic        d_valid_reg, imem_req_reg, et_reg, s_reg, ps_reg, z_reg, n_reg;
  logic        dmem_req_reg, dmem_we_reg, fp_valid_reg, irq_ack_reg;
  rip_ex_s     e_reg, e_next;
  rip_wb_s     w_reg;

  // Decode: the major opcode picks one of three layouts
  wire [1:0] d_opc   = d_ir_reg[OP_LSB +: 2];
  wire [5:0] d_op3   = d_ir_reg[OP3_LSB +: 6];
  wire [2:0] d_op2   = d_ir_reg[OP2_LSB +: 3];
  wire [3:0] d_cond  = d_ir_reg[COND_LSB +: 4];
  wire       d_f1    = d_opc == OP_CALL;
  wire       d_f2    = d_opc == OP_FMT2;
  wire       d_f3    = d_opc[1];
  wire       d_alu   = d_opc == OP_ALU;
  wire       d_mem   = d_f3 & ~d_alu;
  wire       d_imm   = d_ir_reg[IMM_BIT];
  wire       d_bcc   = d_f2 & (d_op2 == OP2_BCC);
  wire       d_sethi = d_f2 & (d_op2 == OP2_SETHI);
  wire       d_jmpl  = d_alu & (d_op3 == OP3_JMPL);
  wire       d_rett  = d_alu & (d_op3 == OP3_RETT);
  wire       d_save  = d_alu & (d_op3 == OP3_SAVE);
  wire       d_rest  = d_alu & (d_op3 == OP3_REST);
  wire       d_fp    = d_alu & (d_op3 == OP3_FPOP);
  wire       d_setcc = d_alu & (d_op3 == OP3_ADDCC || d_op3 == OP3_SUBCC);
  wire       d_load  = d_mem & ~d_op3[2];
  wire       d_store = d_mem & d_op3[2];
  wire       d_alt   = d_mem & d_op3[4];
  wire       d_cti   = d_bcc | d_f1 | d_jmpl | d_rett;
  wire       d_plain = d_alu & ~d_save & ~d_rest & ~d_jmpl;

  // Only never/always/equal/not-equal tests; other codes act as never/always
  wire br_true = ((d_cond[2:0] == 3'h1) ? z_reg : 1'b0) ^ d_cond[3];
  wire d_taken = d_bcc ? br_true : (d_f1 | d_jmpl | d_rett);
  wire d_annul = d_bcc & d_ir_reg[ANNUL_BIT] & (~br_true | d_cond == COND_ALWAYS);

  wire [2:0] cwp_win = d_save ? cwp_reg - 3'h1 : d_rest ? cwp_reg + 3'h1 : cwp_reg;
  wire rip_preg_t p_rs1 = rip_phys(d_ir_reg[RS1_LSB +: 5], cwp_reg);
  wire rip_preg_t p_rs2 = rip_phys(d_ir_reg[RS2_LSB +: 5], cwp_reg);
  wire rip_preg_t p_sd  = rip_phys(d_ir_reg[RD_LSB +: 5], cwp_reg);
  wire rip_preg_t p_dst = d_f1 ? rip_phys(LINK_REG, cwp_reg)
                               : rip_phys(d_ir_reg[RD_LSB +: 5], cwp_win);

  logic [31:0] rf1, rf2, rf3, alu_res, w_val;
  logic        rf_we;

  rip_regfile u_rf (
    .clk   (clk),
    .rst_b (rst_b),
    .ra1   (p_rs1),
    .ra2   (p_rs2),
    .ra3   (p_sd),
    .rd1   (rf1),
    .rd2   (rf2),
    .rd3   (rf3),
    .we    (rf_we),
    .wa    (w_reg.rd),
    .wd    (w_val)
  );

  assign alu_res = (e_reg.op == ALU_SUB) ? e_reg.a - e_reg.b :
                   (e_reg.op == ALU_AND) ? e_reg.a & e_reg.b :
                   (e_reg.op == ALU_OR)  ? e_reg.a | e_reg.b :
                   (e_reg.op == ALU_XOR) ? e_reg.a ^ e_reg.b : e_reg.a + e_reg.b;
  assign w_val = w_reg.load ? dmem_rdata : w_reg.res;

  // Bypass from execute and write-back saves most interlock cycles
  // Stage state goes in as arguments so the continuous assignments below see every change
  function automatic logic [31:0] fwd(input rip_preg_t p, input logic [31:0] rf,
    input rip_ex_s e, input rip_wb_s w, input logic [31:0] ev, input logic [31:0] wv);
    if (e.valid && e.wr && e.rd == p) return ev;
    if (w.valid && w.wr && w.rd == p) return wv;
    return rf;
  endfunction

  wire [31:0] simm  = {{19{d_ir_reg[12]}}, d_ir_reg[12:0]};
  wire [31:0] op_a  = fwd(p_rs1, rf1, e_reg, w_reg, alu_res, w_val);
  wire [31:0] op_b  = d_imm ? simm : fwd(p_rs2, rf2, e_reg, w_reg, alu_res, w_val);
  wire [31:0] op_sd = fwd(p_sd, rf3, e_reg, w_reg, alu_res, w_val);

  // Interlocks
  wire lu_hz = e_reg.valid & e_reg.load & e_reg.wr & d_f3 &
               (e_reg.rd == p_rs1 | (~d_imm & e_reg.rd == p_rs2) |
                (d_store & e_reg.rd == p_sd));
  wire cc_hz = d_bcc & e_reg.valid & e_reg.setcc;
  wire fp_hz = d_fp & fp_valid_reg & ~fp_ready;
  wire cw_hz = d_cti & ~imem_ready;
  wire hz    = d_valid_reg & (lu_hz | cc_hz | fp_hz | cw_hz);
  wire mem_wait = dmem_req_reg & ~dmem_ready;
  wire run   = ~mem_wait;
  wire d_adv = run & ~hz;
  wire ddo   = d_adv & d_valid_reg;
  wire irq_pend = |irq_s2_reg;
  // Traps wait while a transfer or window change sits in decode, so no delay slot is lost
  wire take  = d_adv & irq_pend & et_reg & ~(d_valid_reg & (d_cti | d_save | d_rest));
  wire redir = ddo & d_cti & d_taken;

  wire [31:0] irq_vec = TRAP_BASE | {20'h0, TT_IRQ_BASE | {4'h0, irq_s2_reg}, 4'h0};
  wire [31:0] jtgt    = op_a + op_b;
  wire [31:0] target  = d_rett ? trap_pc_reg :
                        d_jmpl ? {jtgt[31:2], 2'h0} :
                        d_f1   ? d_pc_reg + {d_ir_reg[29:0], 2'h0} :
                                 d_pc_reg + {{8{d_ir_reg[21]}}, d_ir_reg[21:0], 2'h0};
  wire [31:0] pc_next = take  ? irq_vec :
                        redir ? target :
                        (d_adv & imem_ready) ? pc_reg + 32'h4 : pc_reg;
  wire s_next = take ? 1'b1 : (ddo & d_rett) ? ps_reg : s_reg;
  wire d_valid_next = imem_ready & ~take & ~(ddo & d_cti & d_annul);

  always_comb begin
    e_next       = '0;
    e_next.valid = ddo;
    e_next.op    = ~d_plain ? ALU_ADD : d_op3[2] ? ALU_SUB :
                   (d_op3[1:0] == 2'h1) ? ALU_AND :
                   (d_op3[1:0] == 2'h2) ? ALU_OR :
                   (d_op3[1:0] == 2'h3) ? ALU_XOR : ALU_ADD;
    e_next.a     = (d_f1 | d_jmpl) ? d_pc_reg : d_sethi ? 32'h0 : op_a;
    e_next.b     = (d_f1 | d_jmpl) ? 32'h0 : d_sethi ? {d_ir_reg[21:0], 10'h0} : op_b;
    e_next.sd    = op_sd;
    e_next.rd    = p_dst;
    e_next.wr    = ddo & ((d_alu & ~d_fp & ~d_rett) | d_load | d_sethi | d_f1) &
                   (p_dst != 8'h00);
    e_next.load  = ddo & d_load;
    e_next.store = ddo & d_store;
    e_next.setcc = ddo & d_setcc;
    e_next.asi   = d_alt ? d_ir_reg[ASI_LSB +: 8] : (s_reg ? ASI_SUP_DATA : ASI_USER_DATA);
  end

  assign rf_we = run & w_reg.valid & w_reg.wr;

  // Interrupt level synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_s1_reg <= 4'h0;
      irq_s2_reg <= 4'h0;
    end else begin
      irq_s1_reg <= irq_level;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // Fetch and decode stages
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg       <= RESET_PC;
      imem_req_reg <= 1'b0;
      imem_asi_reg <= ASI_SUP_INSN;
      d_valid_reg  <= 1'b0;
      d_ir_reg     <= 32'h0;
      d_pc_reg     <= RESET_PC;
    end else begin
      imem_req_reg <= 1'b1;
      pc_reg       <= pc_next;
      imem_asi_reg <= s_next ? ASI_SUP_INSN : ASI_USER_INSN;
      if (d_adv) begin
        d_valid_reg <= d_valid_next;
        d_ir_reg    <= imem_rdata;
        d_pc_reg    <= pc_reg;
      end
    end
  end

  // Processor state: window pointer, trap enable, modes, condition codes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cwp_reg     <= CWP_RESET;
      et_reg      <= ET_RESET;
      s_reg       <= S_RESET;
      ps_reg      <= S_RESET;
      z_reg       <= 1'b0;
      n_reg       <= 1'b0;
      trap_pc_reg <= RESET_PC;
    end else begin
      s_reg <= s_next;
      if (take) begin
        cwp_reg     <= cwp_reg - 3'h1;
        et_reg      <= 1'b0;
        ps_reg      <= s_reg;
        trap_pc_reg <= pc_reg;
      end else if (ddo) begin
        cwp_reg <= d_rett ? cwp_reg + 3'h1 : cwp_win;
        if (d_rett) begin
          et_reg <= 1'b1;
        end
      end
      if (run && e_reg.valid && e_reg.setcc) begin
        z_reg <= alu_res == 32'h0;
        n_reg <= alu_res[31];
      end
    end
  end

  // Execute and write-back stages; a memory wait freezes the whole pipe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      e_reg          <= '0;
      w_reg          <= '0;
      dmem_req_reg   <= 1'b0;
      dmem_we_reg    <= 1'b0;
      dmem_addr_reg  <= 32'h0;
      dmem_asi_reg   <= 8'h00;
      dmem_wdata_reg <= 32'h0;
    end else if (run) begin
      e_reg          <= e_next;
      w_reg          <= '{valid: e_reg.valid, wr: e_reg.wr, load: e_reg.load,
                          rd: e_reg.rd, res: alu_res};
      dmem_req_reg   <= e_reg.valid & (e_reg.load | e_reg.store);
      dmem_we_reg    <= e_reg.store;
      dmem_addr_reg  <= {alu_res[31:2], 2'h0};
      dmem_asi_reg   <= e_reg.asi;
      dmem_wdata_reg <= e_reg.sd;
    end
  end

  // Coprocessor dispatch and interrupt acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_valid_reg <= 1'b0;
      fp_instr_reg <= 32'h0;
      irq_ack_reg  <= 1'b0;
      irq_lvl_reg  <= 4'h0;
    end else begin
      if (ddo && d_fp) begin
        fp_valid_reg <= 1'b1;
        fp_instr_reg <= d_ir_reg;
      end else if (fp_ready) begin
        fp_valid_reg <= 1'b0;
      end
      irq_ack_reg <= take;
      if (take) begin
        irq_lvl_reg <= irq_s2_reg;
      end
    end
  end

  assign imem_req      = imem_req_reg;
  assign imem_addr     = pc_reg;
  assign imem_asi      = imem_asi_reg;
  assign dmem_req      = dmem_req_reg;
  assign dmem_we       = dmem_we_reg;
  assign dmem_addr     = dmem_addr_reg;
  assign dmem_asi      = dmem_asi_reg;
  assign dmem_wdata    = dmem_wdata_reg;
  assign fp_valid      = fp_valid_reg;
  assign fp_instr      = fp_instr_reg;
  assign irq_ack       = irq_ack_reg;
  assign irq_ack_level = irq_lvl_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  fetch_align_a: assert property (imem_addr[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  one_format_a: assert property (d_valid_reg |-> $onehot({d_f1, d_f2, d_f3}))
    else $error("decode layout not unique");
  mem_cause_a: assert property (
    $rose(dmem_req) |-> $past(e_reg.valid && (e_reg.load || e_reg.store)))
    else $error("memory access without load or store");
  annul_slot_a: assert property (ddo && d_cti && d_annul |=> !d_valid_reg)
    else $error("annulled delay slot issued");
  slot_kept_a: assert property (
    ddo && d_cti && !d_annul && !take |=> d_valid_reg && d_pc_reg == $past(pc_reg))
    else $error("delay slot not fetched");
  ack_pulse_a: assert property (
    irq_pend && et_reg && run && !hz && !(d_valid_reg && (d_cti || d_save || d_rest))
    |=> irq_ack ##1 !irq_ack)
    else $error("interrupt not acknowledged in one cycle");
  vec_fetch_a: assert property (
    irq_ack |-> imem_addr == (TRAP_BASE | {20'h0, TT_IRQ_BASE | {4'h0, irq_ack_level}, 4'h0}))
    else $error("service routine not fetched");
  fp_overlap_a: assert property (
    fp_valid && !fp_ready && d_valid_reg && !d_fp && !lu_hz && !cc_hz && !cw_hz && run
    |=> e_reg.valid)
    else $error("integer issue blocked by coprocessor");
  cc_hold_a: assert property (
    d_valid_reg && d_bcc && e_reg.valid && e_reg.setcc && run
    |=> d_valid_reg && $stable(d_ir_reg) && !e_reg.valid)
    else $error("branch not held behind condition update");
  stream_a: assert property (
    d_adv && imem_ready && !take && !redir |=> imem_addr == $past(imem_addr) + 32'h4)
    else $error("sequential fetch did not advance");
  load_use_a: assert property (d_valid_reg && lu_hz && run |=> !e_reg.valid)
    else $error("load result used too early");
  space_code_a: assert property (
    $rose(dmem_req) && !$past(d_alt, 2) |-> dmem_asi == ASI_SUP_DATA || dmem_asi == ASI_USER_DATA)
    else $error("data access space code wrong");
endmodule

// ==== test/rip_mem_model.sv ====
// Memory, instruction store and coprocessor model facing the pipeline
`timescale 1ns/10ps
module rip_mem_model (
  // Clock, reset and wait pattern
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  wt,
  // Fetch side
  input  wire logic        imem_req,
  input  wire logic [31:0] imem_addr,
  output logic [31:0]      imem_rdata,
  output logic             imem_ready,
  // Data side
  input  wire logic        dmem_req,
  input  wire logic        dmem_we,
  input  wire logic [31:0] dmem_addr,
  input  wire logic [7:0]  dmem_asi,
  input  wire logic [31:0] dmem_wdata,
  output logic [31:0]      dmem_rdata,
  output logic             dmem_ready,
  // Coprocessor side
  input  wire logic        fp_valid,
  input  wire logic [31:0] fp_instr,
  output logic             fp_ready
);
  logic [31:0] imem [0:63];
  logic [31:0] dm [0:15];
  logic [72:0] st_q [$];
  logic [31:0] fp_q [$];
  logic [2:0]  fp_cnt;
  logic [31:0] iword;
  logic [31:0] dword;
  // Addresses outside the loaded program read as no-ops
  assign iword = (imem_addr[31:8] == 24'h0) ? imem[imem_addr[7:2]] : 32'h8010_0000;
  assign dword = dm[dmem_addr[5:2]];
  // Idle data lines show the inverted word so a stale sample never looks right
  assign imem_ready = imem_req & ~wt[0];
  assign imem_rdata = imem_ready ? iword : ~iword;
  assign dmem_ready = dmem_req & ~wt[1];
  assign dmem_rdata = dmem_ready ? dword : ~dword;
  // Coprocessor is slow on purpose so integer work must run past it
  assign fp_ready = fp_valid & (fp_cnt == 3'h5);
  initial begin
    for (int i = 0; i < 64; i++) imem[i] = 32'h8010_0000;
    for (int i = 0; i < 16; i++) dm[i] = 32'h0;
  end
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fp_cnt <= 3'h0;
    end else begin
      fp_cnt <= (fp_valid & ~fp_ready) ? fp_cnt + 3'h1 : 3'h0;
      if (dmem_ready & dmem_we) begin
        dm[dmem_addr[5:2]] <= dmem_wdata;
        st_q.push_back({fp_valid, dmem_asi, dmem_addr, dmem_wdata});
      end
      if (fp_ready) fp_q.push_back(fp_instr);
    end
  end
endmodule

// ==== test/rip_tb.sv ====
// Self-checking bench for the integer pipeline
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb;
  import rip_pkg::*;
  logic        clk, rst_b, slow, imem_req, imem_ready, dmem_req, dmem_we, dmem_ready;
  logic        fp_valid, fp_ready, irq_ack;
  logic [1:0]  wt;
  logic [3:0]  irq_level, irq_ack_level, lvl;
  logic [7:0]  imem_asi, dmem_asi;
  logic [31:0] imem_addr, imem_rdata, dmem_addr, dmem_wdata, dmem_rdata, fp_instr;
  logic [31:0] seed, wseed, a32, b32, c32, pa;
  logic [72:0] e;
  int          n, failures, tests_run;

  rip_core uut (.clk(clk), .rst_b(rst_b), .imem_req(imem_req), .imem_addr(imem_addr),
    .imem_asi(imem_asi), .imem_rdata(imem_rdata), .imem_ready(imem_ready),
    .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_asi(dmem_asi),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready),
    .fp_valid(fp_valid), .fp_instr(fp_instr), .fp_ready(fp_ready),
    .irq_level(irq_level), .irq_ack(irq_ack), .irq_ack_level(irq_ack_level));
  rip_mem_model mem (.clk(clk), .rst_b(rst_b), .wt(wt), .imem_req(imem_req),
    .imem_addr(imem_addr), .imem_rdata(imem_rdata), .imem_ready(imem_ready),
    .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_asi(dmem_asi),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .dmem_ready(dmem_ready),
    .fp_valid(fp_valid), .fp_instr(fp_instr), .fp_ready(fp_ready));

  always #12.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] alu(input logic [5:0] op3, input logic [4:0] rd,
                                      input logic [4:0] rs1, input logic i,
                                      input logic [12:0] v);
    return {OP_ALU, rd, op3, rs1, i, v};
  endfunction
  function automatic logic [31:0] mop(input logic st, input logic [4:0] rd,
                                      input logic [12:0] ofs);
    return {2'h3, rd, 3'h0, st, 2'h0, 5'h0, 1'b1, ofs};
  endfunction
  function automatic logic [31:0] bra(input logic a, input logic [21:0] d);
    return {OP_FMT2, a, COND_ALWAYS, OP2_BCC, d};
  endfunction
  function automatic logic [31:0] exp_st(input int k, input logic [31:0] a, b, c);
    case (k)
      0, 7: return a + b;
      1: return a + a + b;
      2: return (a + a + b) << 1;
      3: return 32'h5;
      4: return 32'h9;
      default: return c;
    endcase
  endfunction

  task load_prog;
    mem.imem[0] = alu(6'h02, 5'd1, 5'd0, 1'b1, a32[12:0]);
    mem.imem[1] = alu(6'h02, 5'd2, 5'd0, 1'b1, b32[12:0]);
    mem.imem[2] = alu(6'h00, 5'd3, 5'd1, 1'b0, 13'd2);
    mem.imem[3] = mop(1'b1, 5'd3, 13'h100);
    mem.imem[4] = mop(1'b0, 5'd4, 13'h100);
    // Uses the load result in the very next slot
    mem.imem[5] = alu(6'h00, 5'd5, 5'd4, 1'b0, 13'd1);
    mem.imem[6] = mop(1'b1, 5'd5, 13'h104);
    mem.imem[7] = alu(OP3_FPOP, 5'd2, 5'd1, 1'b0, 13'd3);
    mem.imem[8] = alu(6'h00, 5'd6, 5'd5, 1'b0, 13'd5);
    mem.imem[9] = mop(1'b1, 5'd6, 13'h108);
    mem.imem[10] = alu(6'h02, 5'd7, 5'd0, 1'b1, 13'd5);
    mem.imem[11] = bra(1'b1, 22'd3);
    mem.imem[12] = alu(6'h02, 5'd7, 5'd0, 1'b1, 13'd1);
    mem.imem[13] = alu(6'h02, 5'd7, 5'd0, 1'b1, 13'd2);
    mem.imem[14] = mop(1'b1, 5'd7, 13'h10c);
    mem.imem[15] = bra(1'b0, 22'd3);
    mem.imem[16] = alu(6'h02, 5'd7, 5'd0, 1'b1, 13'd9);
    mem.imem[17] = alu(6'h02, 5'd7, 5'd0, 1'b1, 13'd3);
    mem.imem[18] = mop(1'b1, 5'd7, 13'h110);
    mem.imem[19] = alu(6'h02, 5'd8, 5'd0, 1'b1, c32[12:0]);
    mem.imem[20] = alu(OP3_SAVE, 5'd0, 5'd0, 1'b0, 13'd0);
    mem.imem[21] = mop(1'b1, 5'd24, 13'h114);
    mem.imem[22] = alu(OP3_REST, 5'd0, 5'd0, 1'b0, 13'd0);
    mem.imem[23] = mop(1'b1, 5'd8, 13'h118);
    // Loaded word stored again once the window is back, as the eighth store
    mem.imem[24] = mop(1'b1, 5'd4, 13'h11c);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task timeout(input string nm);
    failures++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    end_of_test();
  endtask

  // Memory waits come from their own generator so they never shift the data draws
  always @(posedge clk) begin
    #2;
    wseed = lfsr(wseed);
    wt = slow ? wseed[1:0] : 2'h0;
  end

  always @(posedge clk) if (rst_b && imem_req) `CHK("fetch align", 2'h0, imem_addr[1:0])

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    slow = 1'b0;
    wt = 2'h0;
    irq_level = 4'h0;
    seed = 32'h0da5;
    wseed = 32'h0da5;
    failures = 0;
    tests_run = 0;
    for (int it = 0; it < 2; it++) begin
      seed = lfsr(seed);
      a32 = {20'h0, seed[11:0]};
      seed = lfsr(seed);
      b32 = {20'h0, seed[11:0]};
      seed = lfsr(seed);
      c32 = {20'h0, seed[11:0]};
      lvl = (seed[15:12] == 4'h0) ? 4'h1 : seed[15:12];
      // Second pass resets in mid-run with random memory waits
      // Off the edge, and after the model has filled its store with no-ops
      #2 rst_b = 1'b0;
      load_prog();
      slow = (it == 1);
      mem.st_q.delete();
      mem.fp_q.delete();
      repeat (12) @(posedge clk);
      `CHK("req in reset", 1'b0, imem_req)
      #2 rst_b = 1'b1;
      @(posedge clk);
      #1 `CHK("fetch space", ASI_SUP_INSN, imem_asi)
      for (n = 0; n < 3000 && mem.st_q.size() < 8; n++) @(posedge clk);
      if (mem.st_q.size() < 8) timeout("stores");
      #1;
      for (int k = 0; k < 8; k++) begin
        e = mem.st_q[k];
        `CHK("store addr", 32'h100 + 32'(4 * k), e[63:32])
        `CHK("store data", exp_st(k, a32, b32, c32), e[31:0])
        `CHK("store space", ASI_SUP_DATA, e[71:64])
      end
      `CHK("fp word", mem.imem[7], mem.fp_q[0])
      if (!slow) begin
        `CHK("fp overlap", 1'b1, mem.st_q[2][72])
        repeat (8) begin
          pa = imem_addr;
          @(posedge clk);
          #1 `CHK("issue rate", pa + 32'h4, imem_addr)
        end
      end
      @(posedge clk);
      #2 irq_level = lvl;
      n = 0;
      while (n < 20 && irq_ack !== 1'b1) begin
        @(posedge clk);
        #1 n++;
      end
      if (n == 20) timeout("irq ack");
      if (!slow) `CHK("ack delay", 1'b1, (n >= 1 && n <= 3))
      `CHK("ack level", lvl, irq_ack_level)
      `CHK("vector", TRAP_BASE | {20'h0, TT_IRQ_BASE | {4'h0, lvl}, 4'h0}, imem_addr)
      if (!slow) `CHK("vector fetch", 1'b1, imem_ready)
      @(posedge clk);
      #1 `CHK("ack pulse", 1'b0, irq_ack)
      irq_level = 4'h0;
      repeat (10) @(posedge clk);
      `CHK("no extra access", 32'd8, 32'(mem.st_q.size()))
      $display("test %0d done", it);
    end
    end_of_test();
  end
endmodule
